// ---- hw/cont_read.sv ----
// continuous main-array read engine, device side, sampling spi pins on clk
`timescale 1ns/1ps
`default_nettype none
// Operation
// - e8 read: three address, four dummy bytes
// - 528 page: 12 page, 10 byte bits
// - 512 page: 12 page, 9 byte bits
// - address counter advances, data streams continuously
// - 1b read: two dummy bytes
// - 0b read: one dummy byte
// - 03 read: data right after address
// - page end rolls into next page
// - array end wraps to first page
// - select rise ends read, output released
// - array read leaves sram buffers untouched
// - all shifting most significant bit first
// - select fall starts, opcode first byte
// - spi modes 0 and 3 supported
module cont_read
   import cread_pkg::*;
#(
   parameter int PAGE_W = PAGE_BITS,
   parameter int BYTE_W_STD = BYTE_BITS_STD,
   parameter int BYTE_W_BIN = BYTE_BITS_BIN
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic page_512,
   output logic so,
   output logic so_oe,
   output logic [21:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_data
);
   phase_t phase_q;
   logic sck_q;
   logic cs_n_q;
   logic [2:0] bit_q;
   logic [7:0] shift_q;
   logic [1:0] abyte_q;
   logic [2:0] dummy_q;
   logic [23:0] addr_q;
   logic [7:0] out_q;
   logic rise;
   logic fall;
   logic active;
   logic byte_done;
   logic start_out;
   logic last_addr_byte;
   logic first_bit;
   logic [7:0] in_byte;

   // address fields are tied to the 22-bit memory port; other sizes cannot be served
   localparam bit SIZES_OK = (PAGE_W == PAGE_BITS) && (BYTE_W_STD == BYTE_BITS_STD)
      && (BYTE_W_BIN == BYTE_BITS_BIN);
   if (!SIZES_OK) begin : g_bad_size
      $error("address field sizes not supported");
   end

   // next linear address with page rollover and array wrap
   function automatic logic [21:0] next_addr(input logic [21:0] a, input logic bin);
      logic [11:0] pg;
      logic [9:0] by;
      // split the linear address into page and byte fields for the active size
      if (bin) begin
         pg = a[20:9];
         by = {1'b0, a[8:0]};
      end else begin
         pg = a[21:10];
         by = a[9:0];
      end
      if (by >= (bin ? PAGE_LAST_BIN : PAGE_LAST_STD)) begin
         by = 10'h000;
         pg = (pg == PAGE_LAST_ARRAY) ? 12'h000 : pg + 12'h001;
      end else begin
         by = by + 10'h001;
      end
      // binary size keeps bit 21 clear so the address stays within 21 bits
      if (bin) begin
         return {1'b0, pg, by[8:0]};
      end
      return {pg, by};
   endfunction

   // mask address bits above the active width
   function automatic logic [21:0] start_addr(input logic [23:0] a, input logic bin);
      if (bin) begin
         return {1'b0, a[20:0]};
      end
      return a[21:0];
   endfunction

   // edge detect on sampled pins; modes 0 and 3 both sample on rise
   // pins are taken as synchronous to clk, so no extra flops sit in the path
   assign rise = sck & ~sck_q & ~cs_n;
   assign fall = ~sck & sck_q & ~cs_n;
   assign active = ~cs_n & ~cs_n_q;
   assign in_byte = {shift_q[6:0], si};
   assign byte_done = rise & (bit_q == 3'h7);
   assign start_out = (phase_q == ST_DATA);
   // last address byte completes: fetch the start byte even if dummies follow
   assign last_addr_byte = byte_done && (phase_q == ST_ADDR) && (abyte_q == 2'(ADDR_BYTES - 1));
   // first bit of each output byte comes straight from the fetched word
   assign first_bit = fall && (bit_q == 3'h0);

   // pin history; cs_n_q idles high so reset never looks like a select edge
   always_ff @(posedge clk) begin
      if (srst) begin
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sck_q <= sck;
         cs_n_q <= cs_n;
      end
   end

   // bit counter and input shift register, cleared while deselected
   // the counter wraps every eight rises, marking the byte borders
   always_ff @(posedge clk) begin
      if (srst || cs_n) begin
         bit_q <= 3'h0;
         shift_q <= 8'h00;
      end else if (rise) begin
         bit_q <= bit_q + 3'h1;
         shift_q <= in_byte;
      end
   end

   // command phase sequencing; select rise aborts at once
   always_ff @(posedge clk) begin
      if (srst || cs_n) begin
         phase_q <= ST_OPCODE;
         abyte_q <= 2'h0;
         dummy_q <= 3'h0;
         addr_q <= 24'h000000;
      end else if (byte_done) begin
         unique case (phase_q)
            // opcode picks the dummy count; anything else is ignored till deselect
            ST_OPCODE: begin
               abyte_q <= 2'h0;
               phase_q <= ST_ADDR;
               unique case (in_byte)
                  OP_READ_LEGACY: dummy_q <= DUMMY_LEGACY;
                  OP_READ_FASTEST: dummy_q <= DUMMY_FASTEST;
                  OP_READ_FAST: dummy_q <= DUMMY_FAST;
                  OP_READ_SLOW: dummy_q <= DUMMY_SLOW;
                  default: phase_q <= ST_IGNORE;
               endcase
            end
            // address arrives high byte first
            ST_ADDR: begin
               addr_q <= {addr_q[15:0], in_byte};
               abyte_q <= abyte_q + 2'h1;
               if (abyte_q == 2'(ADDR_BYTES - 1)) begin
                  phase_q <= (dummy_q == 3'h0) ? ST_DATA : ST_DUMMY;
               end
            end
            // dummy bytes are only counted, their content is dropped
            ST_DUMMY: begin
               dummy_q <= dummy_q - 3'h1;
               if (dummy_q == 3'h1) begin
                  phase_q <= ST_DATA;
               end
            end
            // data and ignore phases last until select rises
            ST_DATA, ST_IGNORE: phase_q <= phase_q;
            default: phase_q <= ST_IGNORE;
         endcase
      end
   end

   // array fetch; memory returns mem_data the cycle after mem_rd, read-only path
   // one fetch per byte, issued at the byte's last rise; the array must answer before the next sck fall
   always_ff @(posedge clk) begin
      if (srst) begin
         mem_addr <= 22'h000000;
         mem_rd <= 1'b0;
      end else begin
         mem_rd <= 1'b0;
         if (last_addr_byte) begin
            mem_addr <= start_addr({addr_q[15:0], in_byte}, page_512);
            mem_rd <= 1'b1;
         end else if (byte_done && start_out) begin
            mem_addr <= next_addr(mem_addr, page_512);
            mem_rd <= 1'b1;
         end
      end
   end

   // output byte register, loaded as each byte starts shifting
   // the first bit bypasses out_q, so out_q only holds the remaining seven
   always_ff @(posedge clk) begin
      if (srst) begin
         out_q <= 8'h00;
      end else if (start_out && first_bit) begin
         out_q <= {mem_data[6:0], 1'b0};
      end else if (start_out && fall) begin
         out_q <= {out_q[6:0], 1'b0};
      end
   end

   // serial output driven on falling sck; released when select rises
   // enable drops one clk after select is seen high
   always_ff @(posedge clk) begin
      if (srst || !active) begin
         so <= 1'b0;
         so_oe <= 1'b0;
      end else if (start_out && fall) begin
         so_oe <= 1'b1;
         so <= first_bit ? mem_data[7] : out_q[7];
      end
   end
endmodule
`default_nettype wire

// ---- hw/cread_pkg.sv ----
// constants for the serial flash continuous read engine
package cread_pkg;
   localparam logic [7:0] OP_READ_LEGACY = 8'he8;
   localparam logic [7:0] OP_READ_FASTEST = 8'h1b;
   localparam logic [7:0] OP_READ_FAST = 8'h0b;
   localparam logic [7:0] OP_READ_SLOW = 8'h03;
   localparam logic [2:0] DUMMY_LEGACY = 3'h4;
   localparam logic [2:0] DUMMY_FASTEST = 3'h2;
   localparam logic [2:0] DUMMY_FAST = 3'h1;
   localparam logic [2:0] DUMMY_SLOW = 3'h0;
   localparam int ADDR_BYTES = 3;
   localparam int PAGE_BITS = 12;
   localparam int BYTE_BITS_STD = 10;
   localparam int BYTE_BITS_BIN = 9;
   localparam logic [9:0] PAGE_LAST_STD = 10'h20f;
   localparam logic [9:0] PAGE_LAST_BIN = 10'h1ff;
   localparam logic [11:0] PAGE_LAST_ARRAY = 12'hfff;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_DATA = 3'b011,
      ST_IGNORE = 3'b100
   } phase_t;
endpackage

// ---- sim/cont_read_sva.sv ----
// assertions on the continuous read engine ports
`timescale 1ns/1ps
`default_nettype none
module cont_read_sva
   import cread_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic page_512,
   input wire logic so,
   input wire logic so_oe,
   input wire logic [21:0] mem_addr,
   input wire logic mem_rd
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   AST_CS_END: assert property (cs_n |=> !so_oe) else $error("oe kept");
   AST_OE_CAUSE: assert property ($fell(so_oe) |-> $past(cs_n)) else $error("oe drop");
   AST_OE_START: assert property ($rose(so_oe) |-> !cs_n && !sck) else $error("oe rise");
   AST_RD_PULSE: assert property (mem_rd |=> !mem_rd) else $error("rd width");
   AST_RD_SEL: assert property (cs_n && $past(cs_n) |-> !mem_rd) else $error("rd idle");
   AST_BIN: assert property (mem_rd && page_512 |-> !mem_addr[21]) else $error("bin");
   AST_STD: assert property (mem_rd && !page_512 |-> mem_addr[9:0] <= PAGE_LAST_STD)
      else $error("std");
   AST_SO_EDGE: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck)
      else $error("so edge");
endmodule
bind cont_read cont_read_sva cont_read_sva_i (.clk(clk), .srst(srst), .cs_n(cs_n), .sck(sck),
   .page_512(page_512), .so(so), .so_oe(so_oe), .mem_addr(mem_addr), .mem_rd(mem_rd));
`default_nettype wire

// ---- sim/spi_host.sv ----
// host spi controller model
`timescale 1ns/1ps
`default_nettype none
module spi_host (
   input wire logic clk,
   input wire logic so,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic got,
   output logic [7:0] rx
);
   // select held low for a whole read; clock idles low or high
   task automatic cs(input logic v, input logic idle);
      @(posedge clk) cs_n <= v;
      repeat (4) @(posedge clk);
      sck <= idle;
      repeat (4) @(posedge clk);
   endtask
   // one byte each way, msb first, 4 clk per level
   task automatic xfer(input logic [7:0] b, input logic cap);
      for (int i = 7; i >= 0; i--) begin
         repeat (4) @(posedge clk);
         sck <= 1'b0;
         si <= b[i];
         repeat (4) @(posedge clk);
         sck <= 1'b1;
         rx[i] <= so;
      end
      got <= cap;
      @(posedge clk);
      got <= 1'b0;
   endtask
   // legacy opcode still issued so that the device side is covered
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      got = 1'b0;
      rx = 8'h00;
   end
endmodule
`default_nettype wire

// ---- sim/test_cont_read.sv ----
// bench for the continuous read engine
`timescale 1ns/1ps
`default_nettype none
module test_cont_read;
   import cread_pkg::*;
   logic clk = 0, srst = 1, page_512 = 0, so, so_oe, mem_rd, cs_n, sck, si, got;
   logic [21:0] mem_addr;
   logic [7:0] mem_data = 8'h00, rx;
   logic [7:0] exp_q[$];
   logic [7:0] ops[4] = '{OP_READ_SLOW, OP_READ_FAST, OP_READ_FASTEST, OP_READ_LEGACY};
   int dums[4] = '{DUMMY_SLOW, DUMMY_FAST, DUMMY_FASTEST, DUMMY_LEGACY};
   int miscompares = 0, comparisons = 0, cyc = 0;
   always #10 clk = ~clk;
   cont_read cont_read_i (.clk(clk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
      .page_512(page_512), .so(so), .so_oe(so_oe), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_data(mem_data));
   spi_host spi_host_i (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si), .got(got), .rx(rx));
   function automatic logic [7:0] pat(logic [21:0] a);
      return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
   endfunction
   // array model, byte valid the cycle after the fetch
   always @(posedge clk) if (mem_rd) mem_data <= pat(mem_addr);
   task automatic check(string n, logic [7:0] e, logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // oldest note against each byte the host collects
   always @(posedge clk) if (got) check("so byte", exp_q.pop_front(), rx);
   task automatic give_verdict();
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   // three bytes starting one before a page end, nd < 0 means refused opcode
   task automatic rd(logic [7:0] op, int nd, logic p5, logic idle, logic [11:0] pg);
      logic [23:0] a;
      logic [21:0] q;
      a = p5 ? {3'($urandom), pg, 9'h1fe} : {2'($urandom), pg, 10'h20e};
      q = p5 ? {1'b0, a[20:0]} : a[21:0];
      @(posedge clk) page_512 <= p5;
      spi_host_i.cs(1'b1, idle);
      spi_host_i.cs(1'b0, idle);
      spi_host_i.xfer(op, 1'b0);
      for (int i = 2; i >= 0; i--) spi_host_i.xfer(a[8*i +: 8], 1'b0);
      repeat (nd) spi_host_i.xfer(8'($urandom), 1'b0);
      for (int i = 0; i < 3; i++) begin
         if (nd >= 0) exp_q.push_back(pat(q));
         q = p5 ? {1'b0, q[20:0] + 21'h1} :
            (q[9:0] == PAGE_LAST_STD ? {q[11+10:10] + 12'h1, 10'h0} : q + 22'h1);
         spi_host_i.xfer(8'($urandom), nd >= 0);
      end
      check("oe on", {7'h0, nd >= 0}, {7'h0, so_oe});
      spi_host_i.cs(1'b1, idle);
      check("oe off", 8'h00, {7'h0, so_oe});
   endtask
   initial begin
      void'($urandom(32'h3aa38b0c));
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      for (int k = 0; k < 4; k++) rd(ops[k], dums[k], k[0], k[1], 12'($urandom));
      rd(OP_READ_FAST, 1, 1'b0, 1'b0, 12'hfff);
      rd(OP_READ_SLOW, 0, 1'b1, 1'b1, 12'hfff);
      rd(8'hd2, -1, 1'b0, 1'b0, 12'h005);
      give_verdict();
   end
endmodule
`default_nettype wire
